// >>> hw/mfq_cfg.svh
// Constants of the multi-queue block: offsets, depths, reset values, timing.
// Assumes inclusion by bare name from the package and the top module.
`ifndef MFQ_CFG_SVH
`define MFQ_CFG_SVH

// ****************
// Queue geometry
// ****************
`define MFQ_NQ 4
`define MFQ_LANE 10
`define MFQ_DEPTH 32768
`define MFQ_AW 15
`define MFQ_CW 16
`define MFQ_WW 20

// ****************
// Timing
// ****************
`define MFQ_FALL_THROUGH_TIMING_EDGES 3
`define MFQ_FALL_THROUGH_TIMING_LAST 2'h2

// ****************
// Register byte offsets
// ****************
`define MFQ_OFS_CFG 4'h0
`define MFQ_OFS_OFFSET 4'h4
`define MFQ_OFS_FLAGS 4'h8

// ****************
// Default flag offsets per select code
// ****************
`define MFQ_DEF_OFS0 16'h0007
`define MFQ_DEF_OFS1 16'h003F
`define MFQ_DEF_OFS2 16'h007F
`define MFQ_DEF_OFS3 16'h03FF

// ****************
// Reset values
// ****************
`define MFQ_WAIT_RST 1'h1

`endif

// >>> hw/mfq_pkg.sv
// Types shared by the multi-queue block.
// Assumes mfq_cfg.svh is on the include path.
`default_nettype none
`include "mfq_cfg.svh"

package mfq_pkg;

   typedef enum logic [1:0] {
      MFQ_IDLE = 2'b01,
      MFQ_ACK  = 2'b10
   } mfq_bus_st_t;

   typedef struct packed {
      logic quad;
      logic iw20;
      logic ow20;
      logic write_double_rate;
      logic read_double_rate;
      logic fall_through_timing;
      logic level_standard_select;
      logic flag_timing_select;
      logic [1:0] fsel;
   } mfq_cfg_t;

   typedef struct packed {
      mfq_bus_st_t st;
      logic waitreq;
      logic [31:0] rdata;
      logic mc_s1;
      logic mc_s2;
      logic mc_s3;
      logic [3:0] qc_s1;
      logic [3:0] qc_s2;
      mfq_cfg_t cfg;
      logic [15:0] ofs_n;
      logic [15:0] ofs_m;
      logic [3:0][14:0] wptr;
      logic [3:0][14:0] rptr;
      logic [3:0][15:0] cnt;
      logic [3:0][1:0] fcnt;
      logic [3:0] valid;
      logic [3:0][19:0] qout;
      logic [3:0] ef_n;
      logic [3:0] ff_n;
      logic [3:0] pae_n;
      logic [3:0] paf_n;
      logic [39:0] q;
      logic [39:0] q_oe;
   } mfq_state_t;

endpackage

`default_nettype wire

// >>> hw/mfq_top.sv
// Four 10-bit queues or two 10/20-bit queues with configuration latching,
// master and per-queue clears, flags and an Avalon-MM register slave.
// Assumes writer and reader logic on i_clk; clear pins arrive asynchronously.
//
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`default_nettype none
`include "mfq_cfg.svh"

module mfq_top (
   // Clock, enable and reset
   input wire logic i_clk,
   input wire logic i_ce,
   input wire logic i_rstn,
   // Clears from pins
   input wire logic i_master_clear_n,
   input wire logic [3:0] i_queue_clear_n,
   // Static configuration pins
   input wire logic i_quad_dual_select,
   input wire logic i_input_width_sel,
   input wire logic i_output_width_sel,
   input wire logic i_write_double_rate,
   input wire logic i_read_double_rate,
   input wire logic i_fall_through_select_serial_in,
   input wire logic i_level_standard_select,
   input wire logic i_flag_timing_select,
   input wire logic [1:0] i_offset_default_select,
   // Write side
   input wire logic [39:0] i_data,
   input wire logic [3:0] i_wr_en,
   // Read side
   input wire logic [3:0] i_rd_en,
   input wire logic [3:0] i_read_select_n,
   input wire logic [3:0] i_out_en_n,
   output logic [39:0] o_q,
   output logic [39:0] o_q_oe,
   // Flags
   output logic [3:0] o_empty_flag_n,
   output logic [3:0] o_full_flag_n,
   output logic [3:0] o_almost_empty_n,
   output logic [3:0] o_almost_full_n,
   // Avalon-MM slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest
);
   import mfq_pkg::*;

   mfq_state_t s;
   mfq_state_t n;
   logic [3:0] wr_acc;
   logic [3:0][19:0] mem_rd;
   logic [19:0] mem [4][`MFQ_DEPTH];

   // ****************
   // Decoding helpers
   // ****************

   // Depth in words shrinks for 20-bit words and for double rate.
   function automatic logic [15:0] cap_of(input mfq_cfg_t c);
      logic [16:0] d;
      d = 17'(`MFQ_DEPTH);
      if (!c.quad && (c.iw20 || c.ow20)) begin
         d = d >> 1;
      end
      if (c.write_double_rate || c.read_double_rate) begin
         d = d >> 1;
      end
      return d[15:0];
   endfunction

   function automatic logic [15:0] def_ofs(input logic [1:0] f);
      case (f)
         2'h0: def_ofs = `MFQ_DEF_OFS0;
         2'h1: def_ofs = `MFQ_DEF_OFS1;
         2'h2: def_ofs = `MFQ_DEF_OFS2;
         default: def_ofs = `MFQ_DEF_OFS3;
      endcase
   endfunction

   function automatic logic [19:0] lane_in(input mfq_cfg_t c, input int k);
      if (!c.quad && c.iw20) begin
         return i_data[(k & 2) * 10 +: 20];
      end
      return {10'h000, i_data[k * 10 +: 10]};
   endfunction

   function automatic logic [31:0] reg_rd(input logic [3:0] a);
      case (a)
         `MFQ_OFS_CFG: reg_rd = {22'h0, s.cfg};
         `MFQ_OFS_OFFSET: reg_rd = {s.ofs_m, s.ofs_n};
         `MFQ_OFS_FLAGS: reg_rd = {16'h0000, s.paf_n, s.pae_n, s.ff_n, s.ef_n};
         default: reg_rd = 32'h00000000;
      endcase
   endfunction

   // ****************
   // Queue storage
   // ****************
   for (genvar g = 0; g < `MFQ_NQ; g++) begin : g_mem
      assign mem_rd[g] = mem[g][s.rptr[g]];
      always_ff @(posedge i_clk) begin
         if (i_ce && wr_acc[g]) begin
            mem[g][s.wptr[g]] <= lane_in(s.cfg, g);
         end
      end
   end

   // ****************
   // Next state
   // ****************
   always_comb begin
      logic mact;
      logic clr;
      logic act;
      logic ld;
      logic used;
      logic oe;
      logic [15:0] cap;
      logic [16:0] lvl;
      int own;
      int sb;
      mact = 1'b0;
      clr = 1'b0;
      act = 1'b0;
      ld = 1'b0;
      used = 1'b0;
      oe = 1'b0;
      cap = '0;
      lvl = '0;
      own = 0;
      sb = 0;
      n = s;
      wr_acc = '0;
      n.mc_s1 = i_master_clear_n;
      n.mc_s2 = s.mc_s1;
      n.mc_s3 = s.mc_s2;
      n.qc_s1 = i_queue_clear_n;
      n.qc_s2 = s.qc_s1;
      mact = !s.mc_s2;
      if (!s.mc_s2 && s.mc_s3) begin
         n.cfg.quad = i_quad_dual_select;
         n.cfg.iw20 = i_input_width_sel;
         n.cfg.ow20 = i_output_width_sel;
         n.cfg.write_double_rate = i_write_double_rate;
         n.cfg.read_double_rate = i_read_double_rate;
         n.cfg.fall_through_timing = i_fall_through_select_serial_in;
         n.cfg.level_standard_select = i_level_standard_select;
         n.cfg.flag_timing_select = i_flag_timing_select;
         n.cfg.fsel = i_offset_default_select;
         n.ofs_n = def_ofs(i_offset_default_select);
         n.ofs_m = def_ofs(i_offset_default_select);
      end
      // Register slave: one wait cycle, then the answer.
      case (s.st)
         MFQ_IDLE: begin
            if (i_avs_read || i_avs_write) begin
               n.st = MFQ_ACK;
               n.rdata = reg_rd(i_avs_address);
            end
         end
         MFQ_ACK: begin
            n.st = MFQ_IDLE;
            if (i_avs_write && i_avs_address == `MFQ_OFS_OFFSET) begin
               for (int b = 0; b < 4; b++) begin
                  if (i_avs_byteenable[b]) begin
                     if (b < 2) begin
                        n.ofs_n[(b % 2) * 8 +: 8] = i_avs_writedata[b * 8 +: 8];
                     end else begin
                        n.ofs_m[(b % 2) * 8 +: 8] = i_avs_writedata[b * 8 +: 8];
                     end
                  end
               end
            end
         end
         default: n.st = MFQ_IDLE;
      endcase
      n.waitreq = (n.st != MFQ_ACK);
      cap = cap_of(n.cfg);
      for (int k = 0; k < `MFQ_NQ; k++) begin
         // queues 1 and 3 only in quad
         act = n.cfg.quad || (k % 2 == 0);
         // queue clear from its own pin
         clr = mact || !s.qc_s2[k] || !act;
         ld = 1'b0;
         if (clr) begin
            n.wptr[k] = '0;
            n.rptr[k] = '0;
            n.cnt[k] = '0;
            n.fcnt[k] = '0;
            n.valid[k] = 1'b0;
            n.qout[k] = '0;
         end else begin
            wr_acc[k] = i_wr_en[k] && (s.cnt[k] < cap);
            if (n.cfg.fall_through_timing) begin
               if (!s.valid[k] && s.cnt[k] != 16'h0000) begin
                  if (s.fcnt[k] == `MFQ_FALL_THROUGH_TIMING_LAST) begin
                     ld = 1'b1;
                     n.fcnt[k] = '0;
                  end else begin
                     n.fcnt[k] = s.fcnt[k] + 2'h1;
                  end
               end else if (s.valid[k] && i_rd_en[k]) begin
                  ld = (s.cnt[k] != 16'h0000);
                  n.valid[k] = ld;
               end
            end else begin
               ld = i_rd_en[k] && (s.cnt[k] != 16'h0000);
            end
            if (ld) begin
               n.qout[k] = mem_rd[k];
               n.rptr[k] = s.rptr[k] + 15'h0001;
               n.valid[k] = n.cfg.fall_through_timing;
            end
            if (wr_acc[k]) begin
               n.wptr[k] = s.wptr[k] + 15'h0001;
            end
            n.cnt[k] = s.cnt[k] + {15'h0000, wr_acc[k]} - {15'h0000, ld};
         end
         lvl = {1'b0, n.cnt[k]} + {16'h0000, n.valid[k]};
         if (n.cfg.fall_through_timing) begin
            n.ef_n[k] = !n.valid[k];
            n.ff_n[k] = (n.cnt[k] >= cap);
         end else begin
            n.ef_n[k] = (n.cnt[k] != 16'h0000);
            n.ff_n[k] = (n.cnt[k] < cap);
         end
         n.pae_n[k] = lvl > {1'b0, n.ofs_n};
         n.paf_n[k] = clr || ((lvl + {1'b0, n.ofs_m}) < {1'b0, cap});
      end
      for (int l = 0; l < `MFQ_NQ; l++) begin
         own = n.cfg.quad ? l : (l & 2);
         sb = (!n.cfg.quad && n.cfg.ow20) ? (l % 2) * 10 : 0;
         used = n.cfg.quad || n.cfg.ow20 || (l % 2 == 0);
         oe = used && !i_out_en_n[own] && (mact || !i_read_select_n[own]);
         n.q[l * 10 +: 10] = n.qout[own][sb +: 10];
         n.q_oe[l * 10 +: 10] = {10{oe}};
      end
   end

   // ****************
   // State register
   // ****************
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s <= '0;
         s.st <= MFQ_IDLE;
         s.waitreq <= `MFQ_WAIT_RST;
      end else if (i_ce) begin
         s <= n;
      end
   end

   assign o_q = s.q;
   assign o_q_oe = s.q_oe;
   assign o_empty_flag_n = s.ef_n;
   assign o_full_flag_n = s.ff_n;
   assign o_almost_empty_n = s.pae_n;
   assign o_almost_full_n = s.paf_n;
   assign o_avs_readdata = s.rdata;
   assign o_avs_waitrequest = s.waitreq;

   // ****************
   // Checks
   // ****************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);

   property p_mclr_ptr;
      (i_ce && !s.mc_s2) |=> (s.wptr == '0 && s.rptr == '0 && o_almost_empty_n == 4'h0
         && o_almost_full_n == 4'hF);
   endproperty
   a_mclr_ptr: assert property (p_mclr_ptr) else $error("clear left pointers or flags");

   property p_std_flags;
      (i_ce && !s.mc_s2 && !n.cfg.fall_through_timing) |=> (o_empty_flag_n == 4'h0 && o_full_flag_n == 4'hF);
   endproperty
   a_std_flags: assert property (p_std_flags) else $error("standard clear flags wrong");

   property p_fall_through_timing_flags;
      (i_ce && !s.mc_s2 && n.cfg.fall_through_timing) |=> (o_full_flag_n == 4'h0 && o_empty_flag_n == 4'hF);
   endproperty
   a_fall_through_timing_flags: assert property (p_fall_through_timing_flags) else $error("fall-through clear flags");

   property p_mclr_q;
      (i_ce && !s.mc_s2) |=> (o_q == 40'h0000000000);
   endproperty
   a_mclr_q: assert property (p_mclr_q) else $error("outputs not zero in clear");

   property p_x10_float;
      (!s.cfg.quad && !s.cfg.ow20 && s.mc_s3 == s.mc_s2) |->
         (o_q_oe[19:10] == 10'h000 && o_q_oe[39:30] == 10'h000);
   endproperty
   a_x10_float: assert property (p_x10_float) else $error("unused x10 lanes driven");

   property p_qclr;
      (i_ce && !s.qc_s2[0]) |=> (s.cnt[0] == 16'h0000 && !o_almost_empty_n[0]
         && o_q[9:0] == 10'h000);
   endproperty
   a_qclr: assert property (p_qclr) else $error("queue clear incomplete");

   property p_fall_through;
      (i_ce && s.cfg.fall_through_timing && s.cnt[0] == 16'h0000 && !s.valid[0] && wr_acc[0] && !i_rd_en[0])
         ##1 (i_ce && s.mc_s2 && s.qc_s2[0])[*3] |=> s.valid[0];
   endproperty
   a_fall_through: assert property (p_fall_through) else $error("first word late");

   property p_cfg_hold;
      (i_ce && s.mc_s2) |=> $stable(s.cfg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config changed outside clear");

   // A queue clear keeps the latched timing mode for its flags.
   property p_qclr_mode;
      (i_ce && !s.qc_s2[2] && s.mc_s2) |=> (o_empty_flag_n[2] == s.cfg.fall_through_timing
         && o_full_flag_n[2] == !s.cfg.fall_through_timing);
   endproperty
   a_qclr_mode: assert property (p_qclr_mode) else $error("queue clear flags wrong");

   // Offsets survive a queue clear while its output lane is zeroed.
   property p_qclr_keep;
      (i_ce && !s.qc_s2[2] && s.mc_s2 && s.st == MFQ_IDLE) |=> ($stable(s.ofs_n)
         && $stable(s.ofs_m) && o_q[29:20] == 10'h000);
   endproperty
   a_qclr_keep: assert property (p_qclr_keep) else $error("queue clear lost offsets");

   property p_dual_idle;
      !s.cfg.quad |-> (s.cnt[1] == 16'h0000 && s.cnt[3] == 16'h0000
         && s.qout[1] == 20'h00000 && s.qout[3] == 20'h00000);
   endproperty
   a_dual_idle: assert property (p_dual_idle) else $error("unused queue holds data");

   // During master clear the drive of each used lane follows its output enable alone.
   property p_mclr_oe;
      (i_ce && !s.mc_s2) |=> (o_q_oe[9:0] == {10{!$past(i_out_en_n[0])}});
   endproperty
   a_mclr_oe: assert property (p_mclr_oe) else $error("clear drive ignores enable");

endmodule // mfq_top

`default_nettype wire

// >>> testbench/mfq_peer.sv
// Writer and reader logic facing the queues on the design clock.
// Assumes the bench calls put and take from one process.
`default_nettype none
module mfq_peer (
   // Clock
   input wire logic i_clk,
   // Towards the queues
   output logic [39:0] o_data,
   output logic [3:0] o_wr_en,
   output logic [3:0] o_rd_en
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_data = 40'h0;
      o_wr_en = 4'h0;
      o_rd_en = 4'h0;
   end
   // Writes n words back to back on the chosen queues.
   task automatic put(input logic [3:0] en, input logic [39:0] d, input int n);
      @(posedge i_clk);
      o_wr_en <= en;
      o_data <= d;
      repeat (n) @(posedge i_clk);
      o_wr_en <= 4'h0;
      // Released data shows the inverse so a stale word never matches.
      o_data <= ~d;
   endtask
   task automatic take(input logic [3:0] en);
      @(posedge i_clk);
      o_rd_en <= en;
      @(posedge i_clk);
      o_rd_en <= 4'h0;
   endtask
endmodule // mfq_peer
`default_nettype wire

// >>> testbench/mfq_top_bench.sv
// Self-checking bench for the multi-queue block with random data.
// Assumes the design package and the peer model are compiled first.
`default_nettype none
module mfq_top_bench;
   import mfq_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic mc_n = 1'b1;
   logic [3:0] qc_n = 4'hF;
   logic [3:0] rsel_n = 4'h0;
   logic [3:0] oe_n = 4'h0;
   mfq_cfg_t cfg = '0;
   logic [3:0] addr = 4'h0;
   logic avs_rd = 1'b0;
   logic avs_wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [39:0] data, q, q_oe, d, prev;
   logic [3:0] wr_en, rd_en, ef_n, ff_n, ae_n, af_n;
   logic [31:0] rdata, r, ofs;
   logic wait_rq;
   logic [31:0] seed = 32'h0000_4C4E;
   int fails = 0;
   int num_checks = 0;

   always #5 clk = ~clk;

   mfq_top u_mfq_top (.i_clk(clk), .i_ce(1'b1), .i_rstn(rstn),
      .i_master_clear_n(mc_n), .i_queue_clear_n(qc_n),
      .i_quad_dual_select(cfg.quad), .i_input_width_sel(cfg.iw20),
      .i_output_width_sel(cfg.ow20), .i_write_double_rate(cfg.write_double_rate),
      .i_read_double_rate(cfg.read_double_rate), .i_fall_through_select_serial_in(cfg.fall_through_timing),
      .i_level_standard_select(cfg.level_standard_select), .i_flag_timing_select(cfg.flag_timing_select),
      .i_offset_default_select(cfg.fsel), .i_data(data), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .i_read_select_n(rsel_n), .i_out_en_n(oe_n), .o_q(q),
      .o_q_oe(q_oe), .o_empty_flag_n(ef_n), .o_full_flag_n(ff_n),
      .o_almost_empty_n(ae_n), .o_almost_full_n(af_n), .i_avs_address(addr),
      .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_writedata(wdata),
      .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq));

   mfq_peer u_mfq_peer (.i_clk(clk), .o_data(data), .o_wr_en(wr_en), .o_rd_en(rd_en));

   // ****************
   // Helpers
   // ****************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] def_ofs(input logic [1:0] s);
      logic [15:0] v;
      case (s)
         2'h0: v = 16'h0007;
         2'h1: v = 16'h003F;
         2'h2: v = 16'h007F;
         default: v = 16'h03FF;
      endcase
      return {v, v};
   endfunction
   function automatic logic [39:0] mask(input mfq_cfg_t c);
      return (c.quad | c.ow20) ? 40'hFF_FFFF_FFFF : 40'h00_3FF0_03FF;
   endfunction
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v,
                      output logic [31:0] rv);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      avs_wr <= w;
      avs_rd <= ~w;
      do begin
         @(posedge clk);
      end while (wait_rq !== 1'b0);
      rv = rdata;
      avs_wr <= 1'b0;
      avs_rd <= 1'b0;
   endtask
   task automatic mclear(input mfq_cfg_t c);
      @(posedge clk);
      cfg <= c;
      rsel_n <= 4'hF;
      @(posedge clk);
      mc_n <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk(40'(ef_n), 40'({4{c.fall_through_timing}}));
      chk(40'(ff_n), 40'({4{~c.fall_through_timing}}));
      chk(40'({af_n, ae_n}), 40'hF0);
      chk(q, 40'h0);
      chk(q_oe, mask(c));
      @(posedge clk);
      oe_n <= 4'hF;
      repeat (2) @(posedge clk);
      #1;
      chk(q_oe, 40'h0);
      @(posedge clk);
      oe_n <= 4'h0;
      rsel_n <= 4'h0;
      mc_n <= 1'b1;
      repeat (6) @(posedge clk);
      bus(1'b0, 4'h0, 32'h0, r);
      chk(40'(r), 40'(c));
      bus(1'b0, 4'h4, 32'h0, r);
      chk(40'(r), 40'(def_ofs(c.fsel)));
      @(posedge clk);
      cfg <= ~c;
      bus(1'b0, 4'h0, 32'h0, r);
      chk(40'(r), 40'(c));
   endtask
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ****************
   // Tests
   // ****************
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      summarize();
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      r = rnd();
      mclear(mfq_cfg_t'({8'h80, r[1:0]}));
      d = {rnd(), rnd()};
      u_mfq_peer.put(4'hF, d, 1);
      #1;
      chk(40'(ef_n), 40'hF);
      u_mfq_peer.take(4'hF);
      #1;
      chk(q, d);
      chk(40'(ef_n), 40'h0);
      ofs = rnd() & 32'h00FF_FFFF;
      bus(1'b1, 4'h4, ofs, r);
      bus(1'b0, 4'hC, 32'h0, r);
      chk(40'(r), 40'h0);
      prev = d;
      u_mfq_peer.put(4'h6, {rnd(), rnd()}, 1);
      @(posedge clk);
      qc_n <= 4'hB;
      repeat (6) @(posedge clk);
      #1;
      chk(40'(ef_n), 40'h2);
      chk(40'({af_n, ff_n}), 40'hFF);
      chk(q, {prev[39:30], 10'h0, prev[19:0]});
      @(posedge clk);
      qc_n <= 4'hF;
      repeat (6) @(posedge clk);
      bus(1'b0, 4'h4, 32'h0, r);
      chk(40'(r), 40'(ofs));
      $display("Test quad standard done");
      mclear(mfq_cfg_t'(10'h000));
      u_mfq_peer.put(4'hA, {rnd(), rnd()}, 1);
      #1;
      chk(40'(ef_n), 40'h0);
      d = {rnd(), rnd()};
      u_mfq_peer.put(4'h5, d, 1);
      u_mfq_peer.take(4'h5);
      #1;
      chk(q & 40'h00_3FF0_03FF, d & 40'h00_3FF0_03FF);
      chk(q_oe, 40'h00_3FF0_03FF);
      $display("Test dual x10 done");
      mclear(mfq_cfg_t'(10'h190));
      d = {rnd(), rnd()};
      u_mfq_peer.put(4'h5, d, 1);
      repeat (2) @(posedge clk);
      #1;
      chk(40'(ef_n & 4'h5), 40'h5);
      @(posedge clk);
      #1;
      chk(40'(ef_n & 4'h5), 40'h0);
      chk(q, d);
      $display("Test dual x20 fall-through done");
      foreach (prev[i]) begin
         if (i < 2) begin
            mclear(mfq_cfg_t'(i == 0 ? 10'h180 : 10'h240));
            u_mfq_peer.put(4'h1, {rnd(), rnd()}, 16383);
            #1;
            chk(40'(ff_n & 4'h1), 40'h1);
            u_mfq_peer.put(4'h1, {rnd(), rnd()}, 1);
            #1;
            chk(40'(ff_n & 4'h1), 40'h0);
         end
      end
      $display("Test halved depth done");
      summarize();
   end
endmodule // mfq_top_bench
`default_nettype wire
